// File: include/complementary_waveform_unit_pkg.sv
// Package: register map, field layout, reset values and types of the complementary waveform unit
package complementary_waveform_unit_pkg;

    // Register byte addresses on the AHB-Lite bus
    localparam logic [31:0] OFF_MAIN_CONTROL = 32'h0000_0000;
    localparam logic [31:0] OFF_POLARITY_CONTROL = 32'h0000_0004;
    localparam logic [31:0] OFF_RISE_DEADBAND = 32'h0000_0008;
    localparam logic [31:0] OFF_FALL_DEADBAND = 32'h0000_000c;
    localparam logic [31:0] OFF_TRIP_OVERRIDE = 32'h0000_0010;
    localparam logic [31:0] OFF_TRIP_ENABLES = 32'h0000_0014;

    // Field positions
    localparam int POS_ENABLE = 7;
    localparam int POS_LOAD = 6;
    localparam int POS_INPUT_LEVEL = 5;
    localparam int POS_SHUTDOWN = 7;
    localparam int POS_RESTART = 6;
    localparam int POS_PAIR_TWO = 4;
    localparam int POS_PAIR_ONE = 2;

    // Reset values
    localparam logic [2:0] RST_MODE = 3'h0;
    localparam logic [3:0] RST_POLARITY = 4'h0;
    localparam logic [5:0] RST_DEADBAND = 6'h00;
    localparam logic [1:0] RST_OVERRIDE = 2'h1;
    localparam logic [4:0] RST_TRIP_ENABLES = 5'h00;
    localparam logic [2:0] TRIP_UNUSED_READ = 3'h7;

    // Mode codes
    localparam logic [2:0] MODE_STEER_ASYNC = 3'h0;
    localparam logic [2:0] MODE_STEER_SYNC = 3'h1;
    localparam logic [2:0] MODE_FULL_FORWARD = 3'h2;
    localparam logic [2:0] MODE_FULL_REVERSE = 3'h3;
    localparam logic [2:0] MODE_HALF_BRIDGE = 3'h4;
    localparam logic [2:0] MODE_PUSH_PULL = 3'h5;

    // Override level codes
    localparam logic [1:0] OVR_HIGH = 2'h3;
    localparam logic [1:0] OVR_LOW = 2'h2;
    localparam logic [1:0] OVR_TRISTATE = 2'h1;
    localparam logic [1:0] OVR_INACTIVE = 2'h0;

    // Latched AHB-Lite address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
    } bus_phase_t;

    // Drive of the four outputs, bit 0 = A .. bit 3 = D
    typedef struct packed {
        logic [3:0] level;
        logic [3:0] enable;
    } quad_drive_t;

endpackage

// File: hdl/complementary_waveform_unit.sv
// Complementary waveform unit: AHB-Lite registers, dead-band engine, output modes and auto-shutdown
// Operation
// - Enable bit turns the generator on
// - Load request transfers buffers at next edge
// - Load request ignored unless already enabled
// - Mode codes select bridge and push-pull schemes
// - Steering codes valid, codes 110/111 reserved
// - Read-only bit shows input waveform level
// - Per-output polarity bit inverts the output
// - Six-bit rising dead-band count, upper zero
// - Six-bit falling dead-band count
// - Shutdown bit set by trip events
// - Software shutdown while disabled forces overrides
// - Overrides hold until next input rising edge
// - Restart bit selects automatic recovery
// - Pair two override codes for B and D
// - Pair one override codes for A and C
// - Five trip source enable bits
// - Auto restart clears shutdown once sources quiet
// - Active-low level trips block shutdown clearing
//
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/100ps
module complementary_waveform_unit
    import complementary_waveform_unit_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic waveform_in,
    input wire logic trip_pin_selector,
    input wire logic timer_two_postscaled,
    input wire logic comparator_one_output,
    input wire logic comparator_two_output,
    input wire logic logic_cell_two_output,
    output logic drive_output_a,
    output logic drive_output_a_oe,
    output logic drive_output_b,
    output logic drive_output_b_oe,
    output logic drive_output_c,
    output logic drive_output_c_oe,
    output logic drive_output_d,
    output logic drive_output_d_oe
);

    // Override level and enable for one output
    function automatic logic [1:0] override_drive(input logic [1:0] code, input logic invert);
        logic [1:0] res;
        res = 2'b10;
        unique case (code)
            OVR_HIGH: res = 2'b11;
            OVR_LOW: res = 2'b10;
            OVR_TRISTATE: res = 2'b00;
            OVR_INACTIVE: res = {1'b1, invert};
        endcase
        return res;
    endfunction

    // Registers
    logic enable;
    logic buffer_load_request;
    logic [2:0] mode;
    logic [3:0] polarity;
    logic [5:0] rise_deadband_count;
    logic [5:0] fall_deadband_count;
    logic shutdown;
    logic restart;
    logic [1:0] override_level_pair_two;
    logic [1:0] override_level_pair_one;
    logic [4:0] trip_enables;
    logic [5:0] active_rise;
    logic [5:0] active_fall;

    // Bus
    bus_phase_t phase;
    logic read_wait;
    wire logic take = hsel & htrans[1] & hready;
    wire logic wr = phase.valid & phase.write;
    wire logic wr_main = wr & (phase.addr == OFF_MAIN_CONTROL);
    wire logic wr_pol = wr & (phase.addr == OFF_POLARITY_CONTROL);
    wire logic wr_rise = wr & (phase.addr == OFF_RISE_DEADBAND);
    wire logic wr_fall = wr & (phase.addr == OFF_FALL_DEADBAND);
    wire logic wr_trip = wr & (phase.addr == OFF_TRIP_OVERRIDE);
    wire logic wr_tren = wr & (phase.addr == OFF_TRIP_ENABLES);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase <= '0;
            read_wait <= 1'b0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            phase <= '{valid: take, write: hwrite, addr: haddr};
            read_wait <= take & ~hwrite;
            hreadyout <= ~(take & ~hwrite);
            hresp <= 1'b0;
        end
    end

    // Input synchronisers: three stages, change accepted when stages two and three agree
    logic [5:0] sync_1;
    logic [5:0] sync_2;
    logic [5:0] sync_3;
    logic [5:0] filtered;
    logic input_prev;
    wire logic [5:0] raw_inputs = {logic_cell_two_output, comparator_two_output, comparator_one_output,
                                   timer_two_postscaled, trip_pin_selector, waveform_in};
    wire logic [5:0] next_filtered = (sync_2 == sync_3) ? sync_3 : filtered;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_1 <= 6'h3e;
            sync_2 <= 6'h3e;
            sync_3 <= 6'h3e;
            filtered <= 6'h3e;
            input_prev <= 1'b0;
        end else begin
            sync_1 <= raw_inputs;
            sync_2 <= sync_1;
            sync_3 <= sync_2;
            filtered <= next_filtered;
            input_prev <= filtered[0];
        end
    end

    wire logic input_level = filtered[0];
    wire logic rise_evt = input_level & ~input_prev;
    wire logic fall_evt = ~input_level & input_prev;
    wire logic trip_active = |(trip_enables & ~filtered[5:1]);

    // Read mux
    wire logic [7:0] rd_main = {enable, buffer_load_request, 3'h0, mode};
    wire logic [7:0] rd_pol = {2'h0, input_level, 1'b0, polarity};
    wire logic [7:0] rd_rise = {2'h0, rise_deadband_count};
    wire logic [7:0] rd_fall = {2'h0, fall_deadband_count};
    wire logic [7:0] rd_trip = {shutdown, restart, override_level_pair_two, override_level_pair_one, 2'h0};
    wire logic [7:0] rd_tren = {TRIP_UNUSED_READ, trip_enables};
    wire logic [7:0] rd_sel = (phase.addr == OFF_MAIN_CONTROL) ? rd_main :
                              (phase.addr == OFF_POLARITY_CONTROL) ? rd_pol :
                              (phase.addr == OFF_RISE_DEADBAND) ? rd_rise :
                              (phase.addr == OFF_FALL_DEADBAND) ? rd_fall :
                              (phase.addr == OFF_TRIP_OVERRIDE) ? rd_trip :
                              (phase.addr == OFF_TRIP_ENABLES) ? rd_tren : 8'h00;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (read_wait) begin
            hrdata <= {24'h00_0000, rd_sel};
        end
    end

    // Buffer load: set only if already enabled, cleared by hardware at an input event
    wire logic load_event = enable & buffer_load_request & (rise_evt | fall_evt);
    wire logic load_set = wr_main & enable & hwdata[POS_LOAD] & hwdata[POS_ENABLE];
    wire logic next_enable = wr_main ? hwdata[POS_ENABLE] : enable;
    wire logic next_load = next_enable & (load_set | (buffer_load_request & ~load_event));

    // Shutdown: trip events set it and win over any clear
    wire logic sw_shutdown = wr_trip ? hwdata[POS_SHUTDOWN] : shutdown;
    wire logic auto_clear = restart & ~wr_trip;
    wire logic next_shutdown = trip_active | (sw_shutdown & ~auto_clear);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable <= 1'b0;
            buffer_load_request <= 1'b0;
            mode <= RST_MODE;
            polarity <= RST_POLARITY;
            rise_deadband_count <= RST_DEADBAND;
            fall_deadband_count <= RST_DEADBAND;
            shutdown <= 1'b0;
            restart <= 1'b0;
            override_level_pair_two <= RST_OVERRIDE;
            override_level_pair_one <= RST_OVERRIDE;
            trip_enables <= RST_TRIP_ENABLES;
        end else begin
            enable <= next_enable;
            buffer_load_request <= next_load;
            shutdown <= next_shutdown;
            if (wr_main) begin
                mode <= hwdata[2:0];
            end
            if (wr_pol) begin
                polarity <= hwdata[3:0];
            end
            if (wr_rise) begin
                rise_deadband_count <= hwdata[5:0];
            end
            if (wr_fall) begin
                fall_deadband_count <= hwdata[5:0];
            end
            if (wr_trip) begin
                restart <= hwdata[POS_RESTART];
                override_level_pair_two <= hwdata[POS_PAIR_TWO +: 2];
                override_level_pair_one <= hwdata[POS_PAIR_ONE +: 2];
            end
            if (wr_tren) begin
                trip_enables <= hwdata[4:0];
            end
        end
    end

    // Active dead-band counts follow the buffers while disabled, else on a load event
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_rise <= RST_DEADBAND;
            active_fall <= RST_DEADBAND;
        end else if (!enable || load_event) begin
            active_rise <= rise_deadband_count;
            active_fall <= fall_deadband_count;
        end
    end

    // Dead-band engine: A side follows rising events, B side falling events
    logic a_act;
    logic b_act;
    logic pend_a;
    logic pend_b;
    logic [5:0] db_cnt;
    logic next_a_act;
    logic next_b_act;
    logic next_pend_a;
    logic next_pend_b;
    logic [5:0] next_db_cnt;

    always_comb begin
        next_a_act = a_act;
        next_b_act = b_act;
        next_pend_a = pend_a;
        next_pend_b = pend_b;
        next_db_cnt = db_cnt;
        if (rise_evt) begin
            next_b_act = 1'b0;
            next_pend_b = 1'b0;
            next_a_act = (active_rise == 6'h00);
            next_pend_a = (active_rise != 6'h00);
            next_db_cnt = active_rise;
        end else if (fall_evt) begin
            next_a_act = 1'b0;
            next_pend_a = 1'b0;
            next_b_act = (active_fall == 6'h00);
            next_pend_b = (active_fall != 6'h00);
            next_db_cnt = active_fall;
        end else if (db_cnt != 6'h00) begin
            next_db_cnt = db_cnt - 6'h01;
            if (db_cnt == 6'h01) begin
                next_a_act = pend_a | a_act;
                next_b_act = pend_b | b_act;
                next_pend_a = 1'b0;
                next_pend_b = 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_act <= 1'b0;
            b_act <= 1'b0;
            pend_a <= 1'b0;
            pend_b <= 1'b0;
            db_cnt <= 6'h00;
        end else begin
            a_act <= next_a_act;
            b_act <= next_b_act;
            pend_a <= next_pend_a;
            pend_b <= next_pend_b;
            db_cnt <= next_db_cnt;
        end
    end

    // Push-pull phase and override hold after shutdown
    logic pp_phase;
    logic override_hold;
    wire logic next_hold = shutdown | (override_hold & ~rise_evt);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pp_phase <= 1'b0;
            override_hold <= 1'b0;
        end else begin
            pp_phase <= rise_evt ? ~pp_phase : pp_phase;
            override_hold <= next_hold;
        end
    end

    // Mode decode, bit order D C B A
    logic [3:0] core;
    always_comb begin
        core = 4'h0;
        unique case (mode)
            MODE_STEER_ASYNC, MODE_STEER_SYNC: core = {4{input_level}};
            MODE_FULL_FORWARD: core = {a_act, 2'b00, 1'b1};
            MODE_FULL_REVERSE: core = {1'b0, 1'b1, a_act, 1'b0};
            MODE_HALF_BRIDGE: core = {b_act, a_act, b_act, a_act};
            MODE_PUSH_PULL: core = {a_act & pp_phase, a_act & ~pp_phase, a_act & pp_phase, a_act & ~pp_phase};
            default: core = 4'h0;
        endcase
    end

    wire logic overriding = shutdown | override_hold;
    wire logic [1:0] ovr_a = override_drive(override_level_pair_one, polarity[0]);
    wire logic [1:0] ovr_b = override_drive(override_level_pair_two, polarity[1]);
    wire logic [1:0] ovr_c = override_drive(override_level_pair_one, polarity[2]);
    wire logic [1:0] ovr_d = override_drive(override_level_pair_two, polarity[3]);
    wire quad_drive_t ovr_drive = '{level: {ovr_d[0], ovr_c[0], ovr_b[0], ovr_a[0]},
                                    enable: {ovr_d[1], ovr_c[1], ovr_b[1], ovr_a[1]}};
    wire quad_drive_t run_drive = '{level: core ^ polarity, enable: 4'hf};
    wire quad_drive_t next_drive = overriding ? ovr_drive :
                                   enable ? run_drive : quad_drive_t'{level: 4'h0, enable: 4'h0};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {drive_output_d, drive_output_c, drive_output_b, drive_output_a} <= 4'h0;
            {drive_output_d_oe, drive_output_c_oe, drive_output_b_oe, drive_output_a_oe} <= 4'h0;
        end else begin
            {drive_output_d, drive_output_c, drive_output_b, drive_output_a} <= next_drive.level;
            {drive_output_d_oe, drive_output_c_oe, drive_output_b_oe, drive_output_a_oe} <= next_drive.enable;
        end
    end

    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence trip_seen;
        trip_active;
    endsequence

    sequence quiet_restart;
        shutdown && restart && !trip_active && !wr_trip;
    endsequence

    chk_load_needs_enable: assert property (wr_main && !enable && hwdata[POS_LOAD] |=> !buffer_load_request)
        else $error("load request set without prior enable");
    chk_load_self_clear: assert property (load_event && !load_set |=> !buffer_load_request)
        else $error("load request not cleared after event");
    chk_trip_sets_shutdown: assert property (trip_seen |=> shutdown)
        else $error("trip did not set shutdown");
    chk_trip_blocks_clear: assert property (trip_seen ##1 (trip_active && wr_trip && !hwdata[POS_SHUTDOWN]) |=> shutdown)
        else $error("shutdown cleared while trip asserted");
    chk_auto_restart: assert property (quiet_restart |=> !shutdown)
        else $error("auto restart failed to clear shutdown");
    chk_manual_restart: assert property (shutdown && !restart && !wr_trip |=> shutdown)
        else $error("shutdown cleared without software");
    chk_hold_to_rise: assert property (override_hold && !shutdown && !rise_evt |=> override_hold)
        else $error("override released before rising edge");
    chk_pair_two_high: assert property (shutdown && override_level_pair_two == OVR_HIGH && !wr_trip
        |=> drive_output_b && drive_output_b_oe && drive_output_d)
        else $error("pair two override level wrong");
    chk_pair_one_tristate: assert property (shutdown && override_level_pair_one == OVR_TRISTATE && !wr_trip
        |=> !drive_output_a_oe && !drive_output_c_oe)
        else $error("pair one not tri-stated");
    chk_reserved_idle: assert property (enable && !overriding && mode[2:1] == 2'b11 && !wr_main && !wr_pol
        |=> drive_output_a == $past(polarity[0]) && drive_output_d == $past(polarity[3]))
        else $error("reserved mode outputs not inactive");
    chk_polarity_steer: assert property (enable && !overriding && mode == MODE_STEER_ASYNC
        |=> drive_output_c == ($past(input_level) ^ $past(polarity[2])))
        else $error("steering output polarity wrong");
    chk_zero_deadband: assert property (rise_evt && active_rise == 6'h00 |=> a_act)
        else $error("zero dead-band delayed output");
    chk_rise_deadband: assert property (rise_evt && active_rise == 6'h02 ##1 !fall_evt ##1 !fall_evt
        |=> a_act)
        else $error("rising dead-band count wrong");

endmodule // complementary_waveform_unit

// File: tb/power_stage_model.sv
// Power stage model: resolves the four gate lines that the unit drives
`timescale 1ns/100ps
module power_stage_model
    import complementary_waveform_unit_pkg::*;
(
    input wire quad_drive_t drive,
    output logic [3:0] gate_level
);
    // Released gate inputs are pulled low by the stage
    assign gate_level = drive.level & drive.enable;
endmodule // power_stage_model

// File: tb/test_complementary_waveform_unit.sv
// Self-checking testbench of the complementary waveform unit
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module test_complementary_waveform_unit;
    import complementary_waveform_unit_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, waveform_in = 0, hreadyout, hresp;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, got, cur_exp;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [4:0] trip_n = 5'h1f;
    logic [3:0] gate, p;
    wire logic [3:0] lvl, oe;
    logic [7:0] r;
    quad_drive_t drive;
    logic [31:0] exp_q[$];
    string nm_q[$];
    string cur_nm;
    int n_errors = 0, n_compared = 0, cycles = 0;
    event got_ev;
    logic [2:0] modes[7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
    logic [3:0] hi_tab[7] = '{4'hf, 4'hf, 4'h9, 4'h6, 4'h5, 4'h0, 4'h0};
    logic [3:0] lo_tab[7] = '{4'h0, 4'h0, 4'h1, 4'h4, 4'ha, 4'h0, 4'h0};

    complementary_waveform_unit i_complementary_waveform_unit (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .waveform_in(waveform_in), .trip_pin_selector(trip_n[0]),
        .timer_two_postscaled(trip_n[1]), .comparator_one_output(trip_n[2]),
        .comparator_two_output(trip_n[3]), .logic_cell_two_output(trip_n[4]),
        .drive_output_a(lvl[0]), .drive_output_a_oe(oe[0]), .drive_output_b(lvl[1]), .drive_output_b_oe(oe[1]),
        .drive_output_c(lvl[2]), .drive_output_c_oe(oe[2]), .drive_output_d(lvl[3]), .drive_output_d_oe(oe[3])
    );
    assign drive = '{level: lvl, enable: oe};
    power_stage_model i_power_stage_model (.drive(drive), .gate_level(gate));

    initial begin
        forever #5 hclk = ~hclk;
    end

    task automatic give_verdict();
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            give_verdict();
        end
    end

    // Result watcher: oldest note against the value just seen
    always @(got_ev) begin
        cur_nm = nm_q.pop_front();
        cur_exp = exp_q.pop_front();
        `CHK(cur_nm, cur_exp, got)
    end

    task automatic expect_val(input string nm, input logic [31:0] e);
        nm_q.push_back(nm);
        exp_q.push_back(e);
    endtask

    task automatic wait_ready();
        do @(negedge hclk); while (hreadyout !== 1'b1);
    endtask

    task automatic addr_phase(input logic [31:0] a, input logic w);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_ready();
        @(posedge hclk);
        htrans <= 2'h0;
    endtask

    task automatic reg_write(input logic [31:0] a, input logic [7:0] d);
        addr_phase(a, 1'b1);
        hwdata <= {24'h0, d};
        wait_ready();
        @(posedge hclk);
    endtask

    task automatic reg_read(input string nm, input logic [31:0] a, input logic [31:0] e);
        expect_val(nm, e);
        addr_phase(a, 1'b0);
        wait_ready();
        got = hrdata;
        -> got_ev;
        @(posedge hclk);
    endtask

    task automatic pins(input string nm, input logic [7:0] e);
        expect_val(nm, {24'h0, e});
        @(posedge hclk);
        @(negedge hclk);
        got = {24'h0, oe, gate};
        -> got_ev;
    endtask

    task automatic set_in(input logic v);
        @(posedge hclk);
        waveform_in <= v;
        repeat (80) @(posedge hclk);
    endtask

    task automatic set_trip(input logic [4:0] t);
        @(posedge hclk);
        trip_n <= t;
        repeat (20) @(posedge hclk);
    endtask

    initial begin
        void'($urandom(32'hcbd3e8e4));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        reg_read("main", OFF_MAIN_CONTROL, 32'h00);
        reg_read("polarity", OFF_POLARITY_CONTROL, 32'h00);
        reg_read("rise", OFF_RISE_DEADBAND, 32'h00);
        reg_read("fall", OFF_FALL_DEADBAND, 32'h00);
        reg_read("override", OFF_TRIP_OVERRIDE, 32'h14);
        reg_read("trip_enables", OFF_TRIP_ENABLES, 32'he0);
        reg_read("unmapped", 32'h18, 32'h00);
        pins("disabled", 8'h00);
        reg_write(OFF_RISE_DEADBAND, 8'hff);
        reg_read("rise", OFF_RISE_DEADBAND, 32'h3f);
        r = 8'($urandom);
        reg_write(OFF_FALL_DEADBAND, r);
        reg_read("fall", OFF_FALL_DEADBAND, {26'h0, r[5:0]});
        reg_write(OFF_TRIP_ENABLES, r);
        reg_read("trip_enables", OFF_TRIP_ENABLES, {24'h0, 3'h7, r[4:0]});
        p = 4'($urandom);
        reg_write(OFF_POLARITY_CONTROL, {4'hf, p});
        reg_read("polarity", OFF_POLARITY_CONTROL, {28'h0, p});
        // Load request with enable set in the same write, then after
        reg_write(OFF_MAIN_CONTROL, 8'hc4);
        reg_read("main", OFF_MAIN_CONTROL, 32'h84);
        reg_write(OFF_MAIN_CONTROL, 8'hc4);
        reg_read("main", OFF_MAIN_CONTROL, 32'hc4);
        set_in(1'b1);
        reg_read("main", OFF_MAIN_CONTROL, 32'h84);
        reg_read("polarity", OFF_POLARITY_CONTROL, {26'h0, 2'h2, p});
        for (int i = 0; i < 7; i++) begin
            reg_write(OFF_MAIN_CONTROL, {5'h10, modes[i]});
            set_in(1'b1);
            pins("mode_high", {4'hf, hi_tab[i] ^ p});
            set_in(1'b0);
            pins("mode_low", {4'hf, lo_tab[i] ^ p});
        end
        reg_write(OFF_MAIN_CONTROL, 8'h85);
        reg_read("main", OFF_MAIN_CONTROL, 32'h85);
        // Trip from comparator one, software recovery
        reg_write(OFF_MAIN_CONTROL, 8'h84);
        reg_write(OFF_TRIP_ENABLES, 8'h04);
        reg_write(OFF_TRIP_OVERRIDE, 8'h34);
        set_trip(5'h1b);
        reg_read("override", OFF_TRIP_OVERRIDE, 32'hb4);
        pins("trip", 8'haa);
        reg_write(OFF_TRIP_OVERRIDE, 8'h34);
        reg_read("override", OFF_TRIP_OVERRIDE, 32'hb4);
        set_trip(5'h1f);
        reg_write(OFF_TRIP_OVERRIDE, 8'h34);
        reg_read("override", OFF_TRIP_OVERRIDE, 32'h34);
        pins("hold", 8'haa);
        set_in(1'b1);
        pins("resume", {4'hf, 4'h5 ^ p});
        // Trip from the pin, automatic recovery
        reg_write(OFF_TRIP_ENABLES, 8'h01);
        reg_write(OFF_TRIP_OVERRIDE, 8'h68);
        set_trip(5'h1e);
        reg_read("override", OFF_TRIP_OVERRIDE, 32'he8);
        pins("auto_trip", 8'hf0);
        set_trip(5'h1f);
        reg_read("override", OFF_TRIP_OVERRIDE, 32'h68);
        // Push-pull alternation, zero then buffered two-cycle rising dead-band
        reg_write(OFF_RISE_DEADBAND, 8'h00);
        reg_write(OFF_MAIN_CONTROL, 8'h05);
        reg_write(OFF_MAIN_CONTROL, 8'h85);
        set_in(1'b0);
        set_in(1'b1);
        pins("push_pull_bd", {4'hf, 4'ha ^ p});
        reg_write(OFF_RISE_DEADBAND, 8'h02);
        reg_write(OFF_MAIN_CONTROL, 8'hc5);
        set_in(1'b0);
        reg_read("main", OFF_MAIN_CONTROL, 32'h85);
        set_in(1'b1);
        pins("push_pull_ac", {4'hf, 4'h5 ^ p});
        // Software shutdown while disabled
        reg_write(OFF_MAIN_CONTROL, 8'h04);
        reg_write(OFF_TRIP_OVERRIDE, 8'hbc);
        pins("soft_shutdown", 8'hff);
        give_verdict();
    end
endmodule // test_complementary_waveform_unit
